// *** sst_chk.sv ***
`timescale 1ns/10ps
module sst_chk
	import sst_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        slow_clk,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	// ======
	// Port checks
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic acc;
	logic hit;
	assign acc = psel && penable;
	assign hit = paddr[1:0] == 2'h0 && paddr <= SST_OFS_IRQ_EN;
	property p_rdy; acc |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_err; acc && !hit |-> pslverr && (pwrite || prdata == 32'h0); endproperty
	a_err: assert property (p_err) else $error("unmapped access");
	property p_ok; !(acc && !hit) |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("stray error");
	property p_rst; $fell(rst) |-> !irq && prdata == 32'h0; endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
	property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rbit; acc && !pwrite && paddr == SST_OFS_MODE |-> !prdata[SST_POS_RESTART]; endproperty
	a_rbit: assert property (p_rbit) else $error("restart bit read");
	property p_stat; acc && !pwrite && paddr == SST_OFS_STATUS |-> prdata[31:2] == 30'h0; endproperty
	a_stat: assert property (p_stat) else $error("status bits");
	property p_mask; acc && pwrite && paddr == SST_OFS_MODE && pwdata[17:16] == 2'h0 |=> ##1 !irq; endproperty
	a_mask: assert property (p_mask) else $error("masked irq");
endmodule : sst_chk

// *** sst_pkg.sv ***
// Behaviour
// - 32-bit counter advances once per prescaler period.
// - Zero divisor means 65536 slow cycles.
// - Divisor 0x8000 at 32.768 kHz gives 1 Hz.
// - Counter wraps from all ones to zero.
// - Increment flag set on every counter advance.
// - Alarm flag set while counter matches alarm.
// - Alarm compares plain value, not value plus one.
// - Alarm register resets to all ones.
// - Flags stay set until status is read or IRQ clear is written.
// - Status read clears both flags.
// - Flag clear lands two slow cycles later.
// - Restart reloads prescaler and zeroes counter.
// - Restart lands two slow cycles after write.
// - Interrupt is flag AND its enable, ORed.
package sst_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0]  SST_OFS_MODE      = 8'h00;
	localparam logic [7:0]  SST_OFS_ALARM     = 8'h04;
	localparam logic [7:0]  SST_OFS_VALUE     = 8'h08;
	localparam logic [7:0]  SST_OFS_STATUS    = 8'h0C;
	localparam logic [7:0]  SST_OFS_IRQ_CLEAR = 8'h10;
	localparam logic [7:0]  SST_OFS_IRQ_EN    = 8'h14;

	// ==========================================================
	// Field positions
	localparam int          SST_POS_ALARM_IEN = 16;
	localparam int          SST_POS_INC_IEN   = 17;
	localparam int          SST_POS_RESTART   = 18;
	localparam int          SST_POS_ALARM_FLG = 0;
	localparam int          SST_POS_INC_FLG   = 1;

	// ==========================================================
	// Reset values
	localparam logic [15:0] SST_RST_DIVISOR   = 16'h8000;
	localparam logic [31:0] SST_RST_ALARM     = 32'hFFFF_FFFF;
	localparam logic [31:0] SST_RST_COUNT     = 32'h0000_0000;

	// ==========================================================
	// Timing
	localparam logic [1:0]  SST_SLOW_DELAY    = 2'h2;

	typedef struct packed {
		logic        increment_irq_enable;
		logic        alarm_irq_enable;
		logic [15:0] prescale_divisor;
	} sst_mode_type;

	typedef struct packed {
		logic increment_flag;
		logic alarm_flag;
	} sst_flags_type;

endpackage : sst_pkg

// *** sst_seconds_timer.sv ***
`timescale 1ns/10ps
module sst_slow_delay
	import sst_pkg::*;
#(
	parameter logic [1:0] TICKS = SST_SLOW_DELAY
)
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic slow_tick,
	output logic      fire
);

	// ==========================================================
	// Slow tick counter
	logic       pend_q;
	logic [1:0] cnt_q;

	// Counting synchronised slow ticks keeps the delay in the bus domain, so no second clock domain exists.
	assign fire = pend_q & slow_tick & (cnt_q == TICKS - 2'h1);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pend_q <= 1'b0;
		end
		else if (start)
		begin
			pend_q <= 1'b1;
		end
		else if (fire)
		begin
			pend_q <= 1'b0;
		end
	end

	// A fresh start restarts the wait, so the action always follows the newest request.
	always_ff @(posedge ref_clk)
	begin
		if (rst || start || fire)
		begin
			cnt_q <= 2'h0;
		end
		else if (pend_q && slow_tick)
		begin
			cnt_q <= cnt_q + 2'h1;
		end
	end

endmodule : sst_slow_delay

module sst_seconds_timer
	import sst_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        slow_clk,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);

	// ==========================================================
	// Slow clock synchroniser and edge detect
	logic        slow_s1_q;
	logic        slow_s2_q;
	logic        slow_s3_q;
	logic        slow_tick;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			slow_s1_q <= 1'b0;
			slow_s2_q <= 1'b0;
			slow_s3_q <= 1'b0;
		end
		else
		begin
			slow_s1_q <= slow_clk;
			slow_s2_q <= slow_s1_q;
			slow_s3_q <= slow_s2_q;
		end
	end

	// The first stage is read only by the second, so no metastable bit reaches the counter.
	assign slow_tick = slow_s2_q & ~slow_s3_q;

	// ==========================================================
	// Bus decode
	logic        acc_wr;
	logic        acc_rd;
	logic        setup;
	logic        mapped;

	assign setup  = psel & ~penable;
	assign acc_wr = psel & penable & pwrite;
	assign acc_rd = psel & penable & ~pwrite;
	assign mapped = (paddr == SST_OFS_MODE) | (paddr == SST_OFS_ALARM) | (paddr == SST_OFS_VALUE)
		| (paddr == SST_OFS_STATUS) | (paddr == SST_OFS_IRQ_CLEAR) | (paddr == SST_OFS_IRQ_EN);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ==========================================================
	// Mode and alarm registers
	sst_mode_type mode_q;
	logic [31:0]  alarm_q;

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mode_q <= '{increment_irq_enable: 1'b0, alarm_irq_enable: 1'b0, prescale_divisor: SST_RST_DIVISOR};
		end
		else if (acc_wr && paddr == SST_OFS_MODE)
		begin
			mode_q.prescale_divisor     <= pwdata[15:0];
			mode_q.alarm_irq_enable     <= pwdata[SST_POS_ALARM_IEN];
			mode_q.increment_irq_enable <= pwdata[SST_POS_INC_IEN];
		end
		else if (acc_wr && paddr == SST_OFS_IRQ_EN)
		begin
			mode_q.alarm_irq_enable     <= pwdata[SST_POS_ALARM_FLG];
			mode_q.increment_irq_enable <= pwdata[SST_POS_INC_FLG];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			alarm_q <= SST_RST_ALARM;
		end
		else if (acc_wr && paddr == SST_OFS_ALARM)
		begin
			alarm_q <= pwdata;
		end
	end

	// ==========================================================
	// Delayed restart
	logic       restart_req;
	logic       restart_fire;

	// A second write restarts the wait, so the newest divisor is the one loaded.
	assign restart_req = acc_wr && paddr == SST_OFS_MODE && pwdata[SST_POS_RESTART];

	sst_slow_delay #(
		.TICKS (SST_SLOW_DELAY)
	) restart_dly_u (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.start     (restart_req),
		.slow_tick (slow_tick),
		.fire      (restart_fire)
	);

	// ==========================================================
	// Prescaler and counter
	logic [15:0] div_q;
	logic [31:0] count_q;
	logic        advance;

	// A zero divisor minus one wraps to all ones, giving 65536 slow cycles.
	assign advance = slow_tick & ~restart_fire & (div_q == mode_q.prescale_divisor - 16'h0001);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			div_q <= 16'h0000;
		end
		else if (restart_fire || advance)
		begin
			div_q <= 16'h0000;
		end
		else if (slow_tick)
		begin
			div_q <= div_q + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			count_q <= SST_RST_COUNT;
		end
		else if (restart_fire)
		begin
			count_q <= SST_RST_COUNT;
		end
		else if (advance)
		begin
			count_q <= count_q + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Status flags with delayed clear
	sst_flags_type flags_q;
	sst_flags_type set_ev;
	sst_flags_type clr_mask_q;
	logic          clr_req;
	logic          clr_fire;
	logic          status_rd;
	logic          irq_clr_wr;

	assign status_rd  = acc_rd && paddr == SST_OFS_STATUS;
	assign irq_clr_wr = acc_wr && paddr == SST_OFS_IRQ_CLEAR;
	assign set_ev.increment_flag = advance;
	// The stored value itself is compared; a match holds the flag while the count stays there.
	assign set_ev.alarm_flag     = (count_q == alarm_q);
	assign clr_req = status_rd | irq_clr_wr;

	sst_slow_delay #(
		.TICKS (SST_SLOW_DELAY)
	) clr_dly_u (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.start     (clr_req),
		.slow_tick (slow_tick),
		.fire      (clr_fire)
	);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			clr_mask_q <= '0;
		end
		else if (clr_req)
		begin
			clr_mask_q <= status_rd ? 2'h3 : (clr_mask_q | pwdata[1:0]);
		end
		else if (clr_fire)
		begin
			clr_mask_q <= '0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			flags_q <= '0;
		end
		else
		begin
			// An event in the clearing cycle wins, so it is never lost.
			flags_q <= (clr_fire ? (flags_q & ~clr_mask_q) : flags_q) | set_ev;
		end
	end

	// ==========================================================
	// Interrupt and read data
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= (flags_q.increment_flag & mode_q.increment_irq_enable)
				| (flags_q.alarm_flag & mode_q.alarm_irq_enable);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (setup && !pwrite)
		begin
			case (paddr)
				SST_OFS_MODE:   prdata <= {14'h0000, mode_q.increment_irq_enable, mode_q.alarm_irq_enable,
					mode_q.prescale_divisor};
				SST_OFS_ALARM:  prdata <= alarm_q;
				SST_OFS_VALUE:  prdata <= count_q;
				SST_OFS_STATUS: prdata <= {30'h0000_0000, flags_q};
				SST_OFS_IRQ_EN: prdata <= {30'h0000_0000, mode_q.increment_irq_enable, mode_q.alarm_irq_enable};
				default:        prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule : sst_seconds_timer

// *** tb_top.sv ***
`timescale 1ns/10ps
module tb_top
	import sst_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        slow_clk = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        irq;
	int          n_errors = 0;
	int          check_count = 0;
	int          seed = 1258;
	always #20 ref_clk = ~ref_clk;
	sst_seconds_timer dut_u (.ref_clk, .rst, .slow_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq);
	// ======
	// Tasks
	task summarize;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1 && ++i < 9);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 9)
		begin
			n_errors++;
			summarize;
		end
	endtask : apb
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	// Slow pulses are gated so that every expected count is exact.
	task slow(input int n);
		repeat (n)
		begin
			slow_clk <= 1'b1;
			repeat (4) @(posedge ref_clk);
			slow_clk <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
	endtask : slow
	// The old prescaler phase s keeps counting until the restart lands on the second tick.
	function automatic logic [31:0] pre_count(input int p, input int d, input int s);
		return 32'(p + int'(s + 1 == d));
	endfunction : pre_count
	task run(input int d, input int k, input int p, input int h, input int s);
		int          i;
		logic [31:0] v;
		apb(1'b1, SST_OFS_MODE, 32'h0007_0000 | 32'(d));
		slow(1);
		rdc(SST_OFS_VALUE, pre_count(p, d, s));
		slow(1);
		rdc(SST_OFS_VALUE, 32'h0);
		apb(1'b1, SST_OFS_ALARM, 32'(k + 1 - h));
		slow(d * k);
		apb(1'b1, SST_OFS_VALUE, $random(seed));
		apb(1'b0, SST_OFS_VALUE, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			v = rd;
			apb(1'b0, SST_OFS_VALUE, 32'h0);
			if (rd === v)
				break;
		end
		chk(rd, 32'(k));
		rdc(SST_OFS_STATUS, 32'(2 + h));
		apb(1'b1, SST_OFS_ALARM, 32'hFFFF_FFFF);
		chk(32'(irq), 32'h1);
		slow(2);
		rdc(SST_OFS_STATUS, 32'h0);
		chk(32'(irq), 32'h0);
	endtask : run
	initial
	begin
		int j;
		int p;
		int d;
		int k;
		p = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		rdc(SST_OFS_MODE, 32'h0000_8000);
		rdc(SST_OFS_ALARM, 32'hFFFF_FFFF);
		rdc(SST_OFS_STATUS, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		for (j = 0; j < 4; j++)
		begin
			d = (j == 3) ? 3 : 4 + $unsigned($random(seed)) % 4;
			k = 1 + $unsigned($random(seed)) % 3;
			run(d, k, p, j % 2, (j == 0) ? 0 : 2);
			p = k;
		end
		apb(1'b1, SST_OFS_MODE, 32'h0000_0003);
		slow(4);
		chk(32'(irq), 32'h0);
		apb(1'b1, SST_OFS_IRQ_EN, 32'h0000_0002);
		repeat (2) @(posedge ref_clk);
		chk(32'(irq), 32'h1);
		apb(1'b1, SST_OFS_IRQ_CLEAR, 32'h0000_0003);
		slow(2);
		chk(32'(irq), 32'h0);
		summarize;
	end
endmodule : tb_top
bind sst_seconds_timer sst_chk chk_u (.ref_clk, .rst, .slow_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .irq);
